// >>> design/psb_pkg.sv
// Shared constants, pin bundles and states of the burst pseudo-static RAM interface
package psb_pkg;

  // Array geometry; storage keeps only the low MEM_AW address bits
  localparam int ADDR_W    = 22;
  localparam int DATA_W    = 16;
  localparam int MEM_AW    = 10;
  localparam int ROW_MSB   = 7;
  localparam int PAGE_LSB  = 4;

  // Bus-config and refresh-config field positions
  localparam int BCR_SYNC_N_BIT = 15;
  localparam int BCR_FIXED_BIT  = 14;
  localparam int BCR_LAT_HI     = 13;
  localparam int BCR_LAT_LO     = 11;
  localparam int BCR_WPOL_BIT   = 10;
  localparam int BCR_WRAP_N_BIT = 3;
  localparam int BCR_LEN_HI     = 2;
  localparam int BCR_LEN_LO     = 0;
  localparam int RCR_PAGE_BIT   = 7;

  // Burst length codes
  localparam logic [2:0] LEN_4    = 3'h1;
  localparam logic [2:0] LEN_8    = 3'h2;
  localparam logic [2:0] LEN_16   = 3'h3;
  localparam logic [2:0] LEN_32   = 3'h4;
  localparam logic [2:0] LEN_CONT = 3'h7;

  // Burst clocks of wait inserted at a row crossing
  localparam logic [1:0] ROW_WAIT_CLKS = 2'h1;

  // Times in ns and derived cycle counts at the 100 MHz system clock
  // RQ25 access and select-low limits kept as constants
  localparam int CLK_PERIOD_NS     = 10;
  localparam int RANDOM_ACCESS_NS  = 60;
  localparam int PAGE_ACCESS_NS    = 30;
  localparam int MAX_SELECT_LOW_NS = 4000;
  localparam int INIT_NS           = 150000;
  localparam int REF_PERIOD_NS     = 3900;
  localparam int REF_BUSY_NS       = 80;
  localparam logic [3:0] RANDOM_ACCESS_CYC =
    4'((RANDOM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PAGE_ACCESS_CYC =
    4'((PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int MAX_SELECT_LOW_CYC = MAX_SELECT_LOW_NS / CLK_PERIOD_NS;
  localparam int INIT_CYCLES = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] REF_PERIOD_CYC = 12'(REF_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [11:0] REF_BUSY_CYC =
    12'((REF_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Control pins from the host controller, all active low except the burst clock
  typedef struct packed {
    logic clk;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic address_valid_n;
    logic upper_byte_en_n;
    logic lower_byte_en_n;
  } psb_pins_t;

  localparam psb_pins_t PINS_IDLE = 7'h3F;

  // Data bus drive: per-byte output enables, low while driving
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0]        oe_n;
  } psb_dq_t;

  // Stall pin drive
  typedef struct packed {
    logic level;
    logic oe_n;
  } psb_wait_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LAT,
    ST_DATA,
    ST_ROWWAIT,
    ST_HOLD
  } psb_state_t;

endpackage

// >>> design/psb_sync2.sv
// Two-flop synchroniser for pin inputs
module psb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [W-1:0] rst_val,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (srst) begin
      // Idle pin levels, so no false select or edge follows reset
      meta_r <= rst_val;
      q      <= rst_val;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // psb_sync2

// >>> design/psb_mem.sv
// Word storage with byte-lane write and combinational read
module psb_mem
  import psb_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                wr_en,
  input  wire logic [1:0]          wr_be,
  input  wire logic [MEM_AW-1:0]   wr_addr,
  input  wire logic [DATA_W-1:0]   wr_data,
  input  wire logic [MEM_AW-1:0]   rd_addr,
  output logic      [DATA_W-1:0]   rd_data
);

  logic [DATA_W-1:0] mem_r [0:(1<<MEM_AW)-1];

  // One lane per byte; a disabled lane keeps its stored value
  for (genvar lane = 0; lane < 2; lane++) begin : g_lane
    always_ff @(posedge clock) begin
      if (wr_en && wr_be[lane]) begin
        mem_r[wr_addr][lane*8 +: 8] <= wr_data[lane*8 +: 8];
      end
    end
  end

  assign rd_data = mem_r[rd_addr];

endmodule // psb_mem

// >>> design/psb_device.sv
// Device-side bus interface of the burst pseudo-static RAM
//
// Contract
// RQ1: Address is captured at first clock rise with address-valid low after select.
// RQ2: Write-enable high at that edge starts burst read, low starts burst write.
// RQ3: Burst lengths 4, 8, 16, 32 words or continuous are configurable.
// RQ4: Continuous burst runs from start address to end of its 256-word row.
// RQ5: Latency count sets clocks before first word; writes always fixed latency.
// RQ6: Variable latency read colliding with refresh stalls until refresh ends.
// RQ7: Fixed latency ignores refresh, controller need not watch the stall output.
// RQ8: Stall asserts at burst start, drops at data, reasserts at unwrapped row end.
// RQ9: After stall drops, one word moves on each burst clock rise.
// RQ10: Controller not watching stall ends bursts itself at row boundaries.
// RQ11: Controller suspends by stopping clock low, using output enable around it.
// RQ12: Stall output stays driven while a burst is suspended.
// RQ13: Controller keeps select low under the maximum time, else restarts burst.
// RQ14: Controller keeps select low until first data word is valid.
// RQ15: Async read with select, output and byte enables low gives data after access time.
// RQ16: Async write commits on first rise of select, write or byte enables.
// RQ17: Async accesses hold clock low; address-valid pulses or stays low.
// RQ18: Page reads reuse the page; change on address bit 4 up restarts full access.
// RQ19: Page reads keep address-valid and clock low; writes never use page mode.
// RQ20: Stall driven meaninglessly in async and page reads, floated in async writes.
// RQ21: Synchronous configuration still accepts async reads and writes with clock low.
// RQ22: Disabled bytes are not written; both disabled floats data bus.
// RQ23: Stall output polarity comes from bus-config bit 10.
// RQ24: Bus-config bit 15 selects synchronous bursts, otherwise async only.
// RQ25: Select-low, random and page access times are design constants.
module psb_device #(
  parameter int INIT_CYCLES = psb_pkg::INIT_CYCLES
) (
  input  wire logic                      clock,
  input  wire logic                      srst,
  input  wire psb_pkg::psb_pins_t        pins,
  input  wire logic [psb_pkg::ADDR_W-1:0] addr,
  input  wire logic [psb_pkg::DATA_W-1:0] dq_in,
  input  wire logic [15:0]               bus_config_reg,
  input  wire logic [15:0]               refresh_config_reg,
  output psb_pkg::psb_dq_t               dq_o,
  output psb_pkg::psb_wait_t             wait_o,
  output logic                           ready_r
);
  import psb_pkg::*;

  psb_pins_t         p, pq;
  logic [ADDR_W-1:0] a_s;
  logic [DATA_W-1:0] d_s;
  logic              we_s;

  // All pins cross into the system clock before use
  psb_sync2 #(.W($bits(psb_pins_t) + ADDR_W + DATA_W)) u_sync (
    .clock   (clock),
    .srst    (srst),
    .rst_val ({PINS_IDLE, {ADDR_W{1'b0}}, {DATA_W{1'b0}}}),
    .d       ({pins, addr, dq_in}),
    .q       ({p, a_s, d_s})
  );
  assign we_s = p.we_n;

  // Edge history of synchronised pins
  always_ff @(posedge clock) begin
    if (srst) pq <= PINS_IDLE;
    else      pq <= p;
  end

  logic clk_rise, sel, sync_mode, fixed_lat, wait_pol, wrap, page_en;
  logic [3:0] lat_target;
  logic [8:0] len_cfg;
  assign clk_rise  = p.clk & ~pq.clk;
  assign sel       = ~p.ce_n & ready_r;
  // RQ24 mode select bit
  assign sync_mode = ~bus_config_reg[BCR_SYNC_N_BIT];
  assign fixed_lat = bus_config_reg[BCR_FIXED_BIT];
  assign wait_pol  = bus_config_reg[BCR_WPOL_BIT];
  assign wrap      = ~bus_config_reg[BCR_WRAP_N_BIT];
  assign page_en   = refresh_config_reg[RCR_PAGE_BIT];
  assign lat_target = (bus_config_reg[BCR_LAT_HI:BCR_LAT_LO] == 3'h0) ? 4'h1 :
                      {1'b0, bus_config_reg[BCR_LAT_HI:BCR_LAT_LO]};

  // RQ3 burst length decode; zero means continuous
  always_comb begin
    case (bus_config_reg[BCR_LEN_HI:BCR_LEN_LO])
      LEN_4:   len_cfg = 9'h004;
      LEN_8:   len_cfg = 9'h008;
      LEN_16:  len_cfg = 9'h010;
      LEN_32:  len_cfg = 9'h020;
      default: len_cfg = 9'h000;
    endcase
  end

  // Power-up self-initialisation; the device ignores the bus until done
  logic [23:0] init_cnt_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      init_cnt_r <= 24'h000000;
      ready_r    <= 1'b0;
    end else if (!ready_r) begin
      init_cnt_r <= init_cnt_r + 24'h000001;
      if (init_cnt_r == 24'(INIT_CYCLES - 1)) ready_r <= 1'b1;
    end
  end

  // Hidden refresh: a busy window at the start of every period
  logic [11:0] ref_cnt_r;
  logic        ref_busy_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      ref_cnt_r  <= 12'h000;
      ref_busy_r <= 1'b0;
    end else begin
      ref_cnt_r  <= (ref_cnt_r == REF_PERIOD_CYC - 12'h001) ? 12'h000 : ref_cnt_r + 12'h001;
      ref_busy_r <= ref_cnt_r < REF_BUSY_CYC;
    end
  end

  psb_state_t        st_r;
  logic [ADDR_W-1:0] baddr_r;
  logic              bwrite_r, bvar_r, bwrap_r, hold_wait_r;
  logic [8:0]        blen_r, wcnt_r;
  logic [3:0]        lcnt_r;
  logic [1:0]        rwait_r;
  logic              burst_start, lat_done, var_stall, last_word, row_end;

  // RQ1 capture condition; RQ21 async accesses also allowed in sync mode
  assign burst_start = sync_mode & sel & clk_rise & ~p.address_valid_n &
                       (st_r == ST_IDLE || st_r == ST_HOLD);
  assign lat_done  = (lcnt_r + 4'h1) >= lat_target;
  // RQ7 fixed latency and writes never consult refresh
  assign var_stall = bvar_r & ~bwrite_r & ref_busy_r;
  assign last_word = (blen_r != 9'h000) && (wcnt_r == blen_r - 9'h001);
  assign row_end   = (baddr_r[ROW_MSB:0] == 8'hFF) & ~(bwrap_r & (blen_r != 9'h000));

  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [8:0] len,
                                                  input logic wr);
    logic [ADDR_W-1:0] m;
    m = {13'h0000, len - 9'h001};
    if (wr && len != 9'h000) next_addr = (a & ~m) | ((a + 22'h000001) & m);
    else                     next_addr = a + 22'h000001;
  endfunction

  // Burst sequencing; a suspended clock simply produces no edges
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r        <= ST_IDLE;
      baddr_r     <= '0;
      bwrite_r    <= 1'b0;
      bvar_r      <= 1'b0;
      bwrap_r     <= 1'b0;
      blen_r      <= 9'h000;
      wcnt_r      <= 9'h000;
      lcnt_r      <= 4'h0;
      rwait_r     <= 2'h0;
      hold_wait_r <= 1'b0;
    end else if (!sel) begin
      st_r <= ST_IDLE;
    end else if (burst_start) begin
      // RQ1 address capture
      baddr_r     <= a_s;
      // RQ2 direction from write-enable
      bwrite_r    <= ~p.we_n;
      // RQ5 writes are always fixed latency
      bvar_r      <= ~fixed_lat & p.we_n;
      bwrap_r     <= wrap;
      blen_r      <= len_cfg;
      wcnt_r      <= 9'h000;
      lcnt_r      <= 4'h0;
      hold_wait_r <= 1'b0;
      st_r        <= ST_LAT;
    end else if (clk_rise) begin
      case (st_r)
        ST_LAT: begin
          // RQ5 count latency clocks; RQ6 stretch while refresh busy
          if (lat_done && !var_stall) st_r <= ST_DATA;
          else if (!lat_done) lcnt_r <= lcnt_r + 4'h1;
        end
        ST_DATA: begin
          // RQ9 one word per clock rise
          baddr_r <= next_addr(baddr_r, blen_r, bwrap_r);
          wcnt_r  <= wcnt_r + 9'h001;
          if (last_word) begin
            st_r <= ST_HOLD;
          end else if (row_end && blen_r == 9'h000) begin
            // RQ4 continuous burst stops at row end
            st_r        <= ST_HOLD;
            hold_wait_r <= 1'b1;
          end else if (row_end) begin
            // RQ8 stall again across the row boundary
            st_r    <= ST_ROWWAIT;
            rwait_r <= 2'h0;
          end
        end
        ST_ROWWAIT: begin
          rwait_r <= rwait_r + 2'h1;
          if (rwait_r + 2'h1 >= ROW_WAIT_CLKS) st_r <= ST_DATA;
        end
        ST_HOLD: st_r <= ST_HOLD;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Async access path, only with the burst clock held low
  logic              async_ok, ar_on, ar_on_r, ar_valid_r, pg_ok_r;
  logic              aw_on, aw_on_r, aw_done_r, aw_fire;
  logic [ADDR_W-1:0] a_lat_r, acc_addr, acc_q_r, aw_addr_r;
  logic [ADDR_W-1:PAGE_LSB] pg_base_r;
  logic [3:0]        ar_cnt_r;
  logic [DATA_W-1:0] aw_data_r;
  logic [1:0]        aw_be_r;
  assign async_ok = sel & (st_r == ST_IDLE) & ~p.clk;
  // RQ17 address transparent while address-valid low, held after its rise
  assign acc_addr = p.address_valid_n ? a_lat_r : a_s;
  // RQ15 async read conditions
  assign ar_on    = async_ok & ~p.oe_n & p.we_n;
  assign aw_on    = async_ok & ~p.we_n & ~(p.upper_byte_en_n & p.lower_byte_en_n);
  // RQ16 commit on first rise among select, write and either byte enable
  assign aw_fire  = aw_on_r & ~aw_done_r & ~burst_start &
                    (~aw_on | (p.upper_byte_en_n & ~pq.upper_byte_en_n) |
                     (p.lower_byte_en_n & ~pq.lower_byte_en_n));

  always_ff @(posedge clock) begin
    if (srst)                   a_lat_r <= '0;
    else if (!p.address_valid_n) a_lat_r <= a_s;
  end

  // Access timer; page hits take the short time
  always_ff @(posedge clock) begin
    if (srst) begin
      ar_on_r    <= 1'b0;
      ar_valid_r <= 1'b0;
      pg_ok_r    <= 1'b0;
      ar_cnt_r   <= 4'h0;
      acc_q_r    <= '0;
      pg_base_r  <= '0;
    end else begin
      ar_on_r <= ar_on;
      acc_q_r <= acc_addr;
      if (!ar_on) begin
        ar_valid_r <= 1'b0;
        if (!sel) pg_ok_r <= 1'b0;
      end else if (!ar_on_r || acc_addr != acc_q_r) begin
        ar_valid_r <= 1'b0;
        // RQ18 same page reuses the open page, else full access
        if (page_en && pg_ok_r && acc_addr[ADDR_W-1:PAGE_LSB] == pg_base_r)
          ar_cnt_r <= PAGE_ACCESS_CYC - 4'h1;
        else
          ar_cnt_r <= RANDOM_ACCESS_CYC - 4'h1;
      end else if (ar_cnt_r != 4'h0) begin
        ar_cnt_r <= ar_cnt_r - 4'h1;
      end else begin
        ar_valid_r <= 1'b1;
        pg_ok_r    <= 1'b1;
        pg_base_r  <= acc_addr[ADDR_W-1:PAGE_LSB];
      end
    end
  end

  // Async write capture; data of the last fully enabled cycle is kept
  always_ff @(posedge clock) begin
    if (srst) begin
      aw_on_r   <= 1'b0;
      aw_done_r <= 1'b0;
      aw_data_r <= '0;
      aw_be_r   <= 2'h0;
      aw_addr_r <= '0;
    end else begin
      aw_on_r <= aw_on;
      if (!aw_on)       aw_done_r <= 1'b0;
      else if (aw_fire) aw_done_r <= 1'b1;
      if (aw_on && !aw_done_r) begin
        aw_data_r <= d_s;
        aw_be_r   <= ~{p.upper_byte_en_n, p.lower_byte_en_n};
        aw_addr_r <= acc_addr;
      end
    end
  end

  // Write port: burst words or committed async write
  logic              mem_we, bw_go;
  logic [1:0]        mem_be;
  logic [MEM_AW-1:0] mem_waddr, mem_raddr;
  logic [DATA_W-1:0] mem_wdata, mem_rdata;
  assign bw_go = sel & clk_rise & (st_r == ST_DATA) & bwrite_r;
  always_comb begin
    mem_we    = bw_go | aw_fire;
    // RQ22 disabled bytes are not written
    mem_be    = bw_go ? ~{p.upper_byte_en_n, p.lower_byte_en_n} : aw_be_r;
    mem_waddr = bw_go ? baddr_r[MEM_AW-1:0] : aw_addr_r[MEM_AW-1:0];
    mem_wdata = bw_go ? d_s : aw_data_r;
  end
  assign mem_raddr = (st_r == ST_IDLE) ? acc_addr[MEM_AW-1:0] : baddr_r[MEM_AW-1:0];

  psb_mem u_mem (
    .clock   (clock),
    .wr_en   (mem_we),
    .wr_be   (mem_be),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (mem_raddr),
    .rd_data (mem_rdata)
  );

  // Data bus drive; output enable high floats it, e.g. during suspend
  always_ff @(posedge clock) begin
    if (srst) begin
      dq_o <= '{data: '0, oe_n: 2'h3};
    end else begin
      dq_o.data <= mem_rdata;
      if (sel && st_r == ST_DATA && !bwrite_r && !p.oe_n)
        dq_o.oe_n <= {p.upper_byte_en_n, p.lower_byte_en_n};
      else if (ar_on && ar_valid_r)
        // RQ22 per-byte enables gate the drive
        dq_o.oe_n <= {p.upper_byte_en_n, p.lower_byte_en_n};
      else
        dq_o.oe_n <= 2'h3;
    end
  end

  // Stall pin; idle level while selected is asserted and meaningless
  logic wait_act;
  assign wait_act = (st_r == ST_LAT) | (st_r == ST_ROWWAIT) | (st_r == ST_IDLE) |
                    ((st_r == ST_HOLD) & hold_wait_r);
  always_ff @(posedge clock) begin
    if (srst) begin
      wait_o <= '{level: 1'b0, oe_n: 1'b1};
    end else begin
      // RQ20 floated during async writes, else driven while selected
      wait_o.oe_n  <= ~sel | aw_on;
      // RQ23 polarity select; RQ12 held through a suspended burst
      wait_o.level <= wait_act ? wait_pol : ~wait_pol;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_burst_go;
    burst_start;
  endsequence
  sequence s_lat_end;
    st_r == ST_LAT && clk_rise && lat_done && !var_stall;
  endsequence

  chk_addr_capture: assert property (s_burst_go |=> baddr_r == $past(a_s)) // RQ1
    else $error("burst address not captured");
  chk_dir_select: assert property (s_burst_go |=> bwrite_r == !$past(we_s)) // RQ2
    else $error("burst direction wrong");
  chk_wait_start: assert property (s_burst_go |-> ##2 wait_o.level == wait_pol) // RQ8
    else $error("stall not asserted at burst start");
  chk_lat_count: assert property (st_r == ST_LAT && clk_rise && !lat_done && sel // RQ5
    |=> st_r == ST_LAT && lcnt_r == $past(lcnt_r) + 4'h1)
    else $error("latency count step wrong");
  chk_fixed_exit: assert property (s_lat_end ##0 !bvar_r ##0 sel // RQ7
    |=> st_r == ST_DATA ##1 wait_o.level == !wait_pol)
    else $error("fixed latency exit wrong");
  chk_refresh_stall: assert property (st_r == ST_LAT && var_stall && sel // RQ6
    |=> st_r == ST_LAT)
    else $error("variable latency ignored refresh");
  chk_data_step: assert property (st_r == ST_DATA && clk_rise && sel && !last_word // RQ9
    && !row_end |=> st_r == ST_DATA && wcnt_r == $past(wcnt_r) + 9'h001)
    else $error("burst word step wrong");
  chk_cont_row: assert property (st_r == ST_DATA && clk_rise && sel && row_end // RQ4
    && blen_r == 9'h000 && !last_word |=> st_r == ST_HOLD ##1 wait_o.level == wait_pol)
    else $error("continuous burst passed row end");
  chk_awrite_float: assert property (aw_on |=> wait_o.oe_n) // RQ20
    else $error("stall driven in async write");
  chk_byte_float: assert property (sel && p.upper_byte_en_n && p.lower_byte_en_n // RQ22
    |=> dq_o.oe_n == 2'h3)
    else $error("data driven with bytes disabled");
  chk_async_commit: assert property (aw_fire |-> mem_we && !$past(aw_done_r)) // RQ16
    else $error("async write commit lost");

endmodule // psb_device

// >>> testbench/psb_host.sv
// Host controller model that drives the memory pins
module psb_host (
  input  wire logic                      clock,
  input  wire logic                      wait_act,
  input  wire psb_pkg::psb_dq_t          dq_o,
  input  wire psb_pkg::psb_wait_t        wait_o,
  output psb_pkg::psb_pins_t             pins,
  output logic [psb_pkg::ADDR_W-1:0]     addr,
  output logic [psb_pkg::DATA_W-1:0]     dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import psb_pkg::*;
  // Eight-cycle burst clock phases outlast the input synchroniser
  localparam int PH = 8;
  logic [DATA_W-1:0] wq[$];
  logic [DATA_W-1:0] rd_q[$];
  psb_dq_t           rd_w;
  logic              wr_flt;
  logic              wt_drv;
  logic              sus_drv;
  logic [DATA_W-1:0] dq_bus;

  // A lane the device releases reads back inverted, so undriven data never matches
  assign dq_bus = dq_o.data ^ {{8{dq_o.oe_n[1]}}, {8{dq_o.oe_n[0]}}};

  // Pins idle with the burst clock low
  initial begin
    pins  = PINS_IDLE;
    addr  = '0;
    dq_in = '0;
  end

  // select held through latency, byte enables low
  task automatic burst(input logic [ADDR_W-1:0] a, input logic wr, input int n, input int rises);
    int   k;
    logic go;
    k = 0;
    sus_drv = 1'b1;
    rd_q.delete();
    @(posedge clock);
    pins <= {1'b0, 1'b0, wr, ~wr, 3'b000};
    addr <= a;
    repeat (PH) @(posedge clock);
    pins.clk <= 1'b1;
    for (int r = 0; r < rises && k < n; r++) begin
      repeat (PH) @(posedge clock);
      pins.clk <= 1'b0;
      pins.address_valid_n <= 1'b1;
      // one suspension mid-read: clock parked low, outputs released, then resumed
      if (!wr && r == 4) begin
        repeat (PH) @(posedge clock);
        pins.oe_n <= 1'b1;
        repeat (PH) @(posedge clock);
        sus_drv = wait_o.oe_n;
        pins.oe_n <= 1'b0;
      end
      // Stall inactive means the next rise moves a word
      go = (wait_o.level === ~wait_act);
      if (go && wr) dq_in <= wq[k];
      repeat (PH) @(posedge clock);
      if (go && !wr) rd_q.push_back(dq_bus);
      k += go;
      pins.clk <= 1'b1;
    end
    repeat (PH) @(posedge clock);
    pins.clk <= 1'b0;
    repeat (PH) @(posedge clock);
    // select dropped once the burst stops
    pins <= PINS_IDLE;
    dq_in <= ~dq_in;
    repeat (PH) @(posedge clock);
  endtask

  // async write with clock low and address-valid low
  task automatic awrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [1:0] be_n);
    @(posedge clock);
    pins <= {5'b00100, be_n};
    addr <= a;
    dq_in <= d;
    repeat (PH) @(posedge clock);
    wr_flt = wait_o.oe_n;
    pins.we_n <= 1'b1;
    repeat (PH) @(posedge clock);
    pins <= PINS_IDLE;
    dq_in <= ~d;
    repeat (PH) @(posedge clock);
  endtask

  // reads keep clock and address-valid low, select kept for page hits
  task automatic aread(input logic [ADDR_W-1:0] a, input int dly, input logic keep,
                       input logic [1:0] be_n);
    @(posedge clock);
    pins <= {5'b00010, be_n};
    addr <= a;
    repeat (dly) @(posedge clock);
    rd_w = dq_o;
    rd_w.data = dq_bus;
    wt_drv = wait_o.oe_n;
    if (!keep) pins <= PINS_IDLE;
    if (!keep) repeat (PH) @(posedge clock);
  endtask
endmodule // psb_host

// >>> testbench/test_psb_device.sv
// Self-checking bench for the burst pseudo-static RAM device interface
module test_psb_device;
  timeunit 1ns;
  timeprecision 1ps;
  import psb_pkg::*;
  logic              clock;
  logic              srst;
  psb_pins_t         pins;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_in;
  logic [15:0]       bus_config_reg;
  logic [15:0]       refresh_config_reg;
  psb_dq_t           dq_o;
  psb_wait_t         wait_o;
  logic              ready_r;
  logic [15:0]       b;
  int                err_total;
  int                cmp_count;

  // Short power-up count keeps the run brief
  psb_device #(.INIT_CYCLES(20)) psb_device_inst (.clock(clock), .srst(srst), .pins(pins),
    .addr(addr), .dq_in(dq_in), .bus_config_reg(bus_config_reg),
    .refresh_config_reg(refresh_config_reg), .dq_o(dq_o), .wait_o(wait_o), .ready_r(ready_r));

  psb_host psb_host_inst (.clock(clock), .wait_act(bus_config_reg[BCR_WPOL_BIT]),
    .dq_o(dq_o), .wait_o(wait_o), .pins(pins), .addr(addr), .dq_in(dq_in));

  // Free-running 100 MHz system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Sync-mode bus config word
  function automatic logic [15:0] cfg(input logic fx, input logic [2:0] lat, input logic pol,
                                      input logic wrap_n, input logic [2:0] len);
    return {1'b0, fx, lat, pol, 6'h00, wrap_n, len};
  endfunction

  // Address of word k; wrap stays inside the aligned block of the burst length
  function automatic logic [ADDR_W-1:0] eaddr(input logic [ADDR_W-1:0] a, input int k,
                                              input logic [15:0] c);
    logic [ADDR_W-1:0] m;
    m = ADDR_W'((2 << c[2:0]) - 1);
    if (!c[BCR_WRAP_N_BIT] && c[2:0] inside {[LEN_4:LEN_32]})
      return (a & ~m) | ((a + ADDR_W'(k)) & m);
    return a + ADDR_W'(k);
  endfunction

  // Test id in the upper byte so stale data never matches
  function automatic logic [15:0] pat(input logic [ADDR_W-1:0] a, input logic [7:0] s);
    return {s, 8'h00} ^ 16'(a[9:0]);
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Burst write then burst read of the same span
  task automatic bt(input logic [7:0] id, input logic [ADDR_W-1:0] a, input int n,
                    input int n_ok, input logic [15:0] c);
    @(posedge clock);
    bus_config_reg <= c;
    psb_host_inst.wq.delete();
    for (int k = 0; k < n; k++) psb_host_inst.wq.push_back(pat(eaddr(a, k, c), id));
    psb_host_inst.burst(a, 1'b1, n, n + 8);
    psb_host_inst.burst(a, 1'b0, n, n + 8);
    check("word count", 16'(n_ok), 16'(psb_host_inst.rd_q.size()));
    for (int k = 0; k < n_ok; k++)
      check("burst word", pat(eaddr(a, k, c), id), psb_host_inst.rd_q[k]);
    check("suspend stall drive", 16'h0, 16'(psb_host_inst.sus_drv));
    $display("test burst %h done", id);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    bus_config_reg = cfg(1'b1, 3'h3, 1'b1, 1'b0, LEN_4);
    refresh_config_reg = 16'h0000;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 200 && ready_r !== 1'b1; i++) @(posedge clock);
    check("ready", 16'h1, 16'(ready_r));
    if (err_total > 0) final_report();
    // Every fixed length, wrapping, variable latency, active-high stall
    for (int c = 1; c <= 4; c++) begin
      b = cfg(1'b0, 3'h3, 1'b1, 1'b0, 3'(c));
      bt(8'(c), ADDR_W'(33 + c * 64), 2 << c, 2 << c, b);
    end
    bt(8'h11, ADDR_W'('h1FC), 8, 8, cfg(1'b1, 3'h2, 1'b0, 1'b1, LEN_8));
    bt(8'h12, ADDR_W'('h2FC), 8, 4, cfg(1'b1, 3'h2, 1'b1, 1'b1, LEN_CONT));
    // Async mode: full write, then lower lane only
    @(posedge clock);
    bus_config_reg <= 16'h8000 | cfg(1'b1, 3'h2, 1'b1, 1'b0, LEN_4);
    psb_host_inst.awrite(ADDR_W'('h300), 16'hA5C3, 2'b00);
    check("write stall float", 16'h1, 16'(psb_host_inst.wr_flt));
    psb_host_inst.awrite(ADDR_W'('h300), 16'h1234, 2'b10);
    psb_host_inst.aread(ADDR_W'('h300), 14, 1'b0, 2'b00);
    check("async read", 16'hA534, psb_host_inst.rd_w.data);
    check("read stall drive", 16'h0, 16'(psb_host_inst.wt_drv));
    psb_host_inst.aread(ADDR_W'('h300), 14, 1'b0, 2'b11);
    check("lanes float", 16'h3, 16'(psb_host_inst.rd_w.oe_n));
    $display("test async done");
    // Page reads: hit answers fast, change above bit 3 starts over
    refresh_config_reg <= 16'h0080;
    psb_host_inst.aread(ADDR_W'('h2FC), 14, 1'b1, 2'b00);
    check("page first", pat(ADDR_W'('h2FC), 8'h12), psb_host_inst.rd_w.data);
    psb_host_inst.aread(ADDR_W'('h2FD), 9, 1'b1, 2'b00);
    check("page hit", pat(ADDR_W'('h2FD), 8'h12), psb_host_inst.rd_w.data);
    psb_host_inst.aread(ADDR_W'('h2ED), 8, 1'b0, 2'b00);
    check("page miss float", 16'h3, 16'(psb_host_inst.rd_w.oe_n));
    $display("test page done");
    // Mixed mode: async write seen by a following burst read
    @(posedge clock);
    refresh_config_reg <= 16'h0000;
    bus_config_reg <= cfg(1'b1, 3'h2, 1'b1, 1'b0, LEN_4);
    psb_host_inst.awrite(ADDR_W'('h3C1), 16'h5E5E, 2'b00);
    psb_host_inst.burst(ADDR_W'('h3C0), 1'b0, 4, 12);
    check("mixed read", 16'h5E5E, psb_host_inst.rd_q[1]);
    $display("test mixed done");
    final_report();
  end
endmodule // test_psb_device
